// >>> include/spg_map.vh
// Register map, field positions, reset values and mode codes of the gating block
// Summary of operation
// - Mode field bits 3:1: 000 idle, 010/011/110/111 deep modes, rest reserved.
// - Sleep instruction sleeps only while the sleep allow bit 0 is set.
// - Reserved bits read zero and ignore writes; software writes zero.
// - General bit 6 stops the USB clock; reinitialise after clearing.
// - General bit 4 stops the cipher engine clock; reinitialise after clearing.
// - General bit 2 gates only the counter's bus side; counting continues.
// - General bit 1 freezes event routing; clearing resumes exactly.
// - General bit 0 stops DMA; setting takes effect only with DMA disabled.
// - Port A bit 1 stops converter, bit 0 comparator, analog cores included.
// - Ports C-F: bit 6 two-wire, 4 serial, 3 SPI, 2 fine-timer extension.
// - Port bits 1 and 0 gate timers 1 and 0; clearing resumes them.
// - SPI only in C and D; fine timer and timer 1 only in C.
// - Gated peripheral is frozen and its registers are inaccessible.
// - Setting a bit of an absent peripheral has no effect.
`ifndef SPG_MAP_VH
`define SPG_MAP_VH

// ==========================================================================
// Word indices (byte address is four times the index)
// ==========================================================================
`define SPG_IDX_GEN 4'h0
`define SPG_IDX_PA 4'h1
`define SPG_IDX_PC 4'h3
`define SPG_IDX_PD 4'h4
`define SPG_IDX_PE 4'h5
`define SPG_IDX_PF 4'h6
`define SPG_IDX_CTRL 4'h8
`define SPG_IDX_STAT 4'h9

// ==========================================================================
// Writable bit masks, reset value
// ==========================================================================
`define SPG_MASK_CTRL 8'h0f
`define SPG_MASK_GEN 8'h57
`define SPG_MASK_PA 8'h03
`define SPG_MASK_PC 8'h5f
`define SPG_MASK_PD 8'h19
`define SPG_MASK_PE 8'h51
`define SPG_MASK_PF 8'h11
`define SPG_RESET 8'h00

// ==========================================================================
// Field positions
// ==========================================================================
`define SPG_SLEEP_ALLOW_BIT 0
`define SPG_MODE_LSB 1
`define SPG_MODE_MSB 3
`define SPG_GEN_USB 6
`define SPG_GEN_CIPHER 4
`define SPG_GEN_RTC 2
`define SPG_GEN_EVT 1
`define SPG_GEN_DMA 0
`define SPG_PA_CONV 1
`define SPG_PA_COMP 0
`define SPG_PT_WIRE 6
`define SPG_PT_SER 4
`define SPG_PT_SPI 3
`define SPG_PT_FINE 2
`define SPG_PT_TMR1 1
`define SPG_PT_TMR0 0

// ==========================================================================
// Sleep mode codes
// ==========================================================================
`define SPG_MODE_IDLE 3'h0
`define SPG_MODE_DEEP_OFF 3'h2
`define SPG_MODE_COUNTER_KEEP 3'h3
`define SPG_MODE_OSC_KEEP 3'h6
`define SPG_MODE_OSC_COUNTER_KEEP 3'h7

`endif

// >>> testbench/spg_chk.sv
// Port checker of the sleep and clock gating block
`timescale 1ns/1ps
module spg_chk (
    // Bus side
    input wire ref_clk,
    input wire rst,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Core side and clock enables
    input wire sleep_instr,
    input wire dma_enabled,
    input wire sleep_req_r,
    input wire [2:0] sleep_mode_r,
    input wire usb_clk_en,
    input wire cipher_clk_en,
    input wire rtc_bus_clk_en,
    input wire event_routing_clk_en,
    input wire dma_clk_en,
    input wire conv_clk_en,
    input wire comp_clk_en,
    input wire [3:0] two_wire_clk_en,
    input wire [3:0] serial0_clk_en,
    input wire [3:0] spi_clk_en,
    input wire [3:0] fine_timer_ext_clk_en,
    input wire [3:0] timer1_clk_en,
    input wire [3:0] timer0_clk_en
);
    // ==================================================================
    // Accepted writes, readable bits per word, sleep control shadow
    localparam [79:0] RD_MASK = 80'h0f0f_0011_5119_5f00_0357;
    wire wr = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire [3:0] w = avs_address[5:2];
    wire [1:0] px = w[1:0] - 2'h3;
    wire [7:0] d = avs_writedata[7:0];
    wire [7:0] rm = (w <= 4'h9) ? RD_MASK[w*8 +: 8] : 8'h00;
    reg [3:0] ctl_r;
    wire [2:0] md = ctl_r[3:1];
    wire go = ctl_r[0] && !(md == 3'h1 || md == 3'h4 || md == 3'h5);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Shadow of allow bit and mode field
    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            ctl_r <= 4'h0;
        else if (wr && w == 4'h8)
            ctl_r <= d[3:0];
    end

    // ==================================================================
    // Properties
    property p_sleep_go;
        sleep_instr && go |=> sleep_req_r && sleep_mode_r == $past(md);
    endproperty
    a_sleep_go: assert property (p_sleep_go)
        else $error("sleep request or mode wrong");
    property p_sleep_no;
        sleep_instr && !go |=> !sleep_req_r;
    endproperty
    a_sleep_no: assert property (p_sleep_no)
        else $error("sleep request not allowed");
    property p_gen;
        wr && w == 4'h0 && !dma_enabled |=> {usb_clk_en, cipher_clk_en,
            rtc_bus_clk_en, event_routing_clk_en, dma_clk_en}
            == ~$past({d[6], d[4], d[2], d[1], d[0]});
    endproperty
    a_gen: assert property (p_gen)
        else $error("general enables wrong");
    property p_dma;
        dma_enabled && dma_clk_en |=> dma_clk_en;
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma clock stopped while enabled");
    property p_pa;
        wr && w == 4'h1 |=> {conv_clk_en, comp_clk_en} == ~$past(d[1:0]);
    endproperty
    a_pa: assert property (p_pa)
        else $error("analog enables wrong");
    property p_port;
        wr && w >= 4'h3 && w <= 4'h6 |=>
            serial0_clk_en[$past(px)] == ~$past(d[4]) &&
            timer0_clk_en[$past(px)] == ~$past(d[0]);
    endproperty
    a_port: assert property (p_port)
        else $error("port enables wrong");
    property p_portc;
        wr && w == 4'h3 |=> {two_wire_clk_en[0], spi_clk_en[0],
            fine_timer_ext_clk_en[0], timer1_clk_en[0]}
            == ~$past({d[6], d[3], d[2], d[1]});
    endproperty
    a_portc: assert property (p_portc)
        else $error("port c enables wrong");
    property p_absent;
        two_wire_clk_en[3] && two_wire_clk_en[1] && &spi_clk_en[3:2] &&
            &fine_timer_ext_clk_en[3:1] && &timer1_clk_en[3:1];
    endproperty
    a_absent: assert property (p_absent)
        else $error("absent peripheral gated");
    property p_rd;
        avs_read && !avs_waitrequest |-> (avs_readdata & ~{24'h0, rm}) == 0;
    endproperty
    a_rd: assert property (p_rd)
        else $error("reserved read bits set");
endmodule // spg_chk

bind spg_top spg_chk spg_chk_i (.ref_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .sleep_instr, .dma_enabled, .sleep_req_r,
    .sleep_mode_r, .usb_clk_en, .cipher_clk_en, .rtc_bus_clk_en,
    .event_routing_clk_en, .dma_clk_en, .conv_clk_en, .comp_clk_en,
    .two_wire_clk_en, .serial0_clk_en, .spi_clk_en, .fine_timer_ext_clk_en,
    .timer1_clk_en, .timer0_clk_en);

// >>> testbench/spg_cpu_model.sv
// Core model issuing the sleep instruction and the DMA enable level
`timescale 1ns/1ps
module spg_cpu_model (
    // Clock, reset and bench commands
    input wire ref_clk,
    input wire rst,
    input wire sleep_cmd,
    input wire dma_on,
    // Core outputs
    output reg sleep_instr,
    output reg dma_enabled
);
    // One-cycle instruction pulse; DMA level follows the command
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sleep_instr <= 1'b0;
            dma_enabled <= 1'b0;
        end else begin
            sleep_instr <= sleep_cmd && !sleep_instr;
            dma_enabled <= dma_on;
        end
    end
endmodule // spg_cpu_model

// >>> testbench/testbench.sv
// Self-checking bench of the sleep and clock gating block
`timescale 1ns/1ps
module testbench;
    // ==================================================================
    // Stimulus, observed signals and bench state
    localparam [71:0] MSK = 72'h0f00_1151_195f_0003_57;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg [5:0] avs_address = 6'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg [3:0] avs_byteenable = 4'h0;
    reg sleep_cmd = 1'b0;
    reg dma_on = 1'b0;
    reg [3:0] be_v = 4'h1;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, sleep_instr, dma_enabled, sleep_req_r;
    wire usb_clk_en, cipher_clk_en, rtc_bus_clk_en, event_routing_clk_en;
    wire dma_clk_en, conv_clk_en, comp_clk_en;
    wire [2:0] sleep_mode_r;
    wire [3:0] two_wire_clk_en, serial0_clk_en, spi_clk_en;
    wire [3:0] fine_timer_ext_clk_en, timer1_clk_en, timer0_clk_en;
    wire [30:0] en_all = {usb_clk_en, cipher_clk_en, rtc_bus_clk_en,
        event_routing_clk_en, dma_clk_en, conv_clk_en, comp_clk_en,
        two_wire_clk_en, serial0_clk_en, spi_clk_en, fine_timer_ext_clk_en,
        timer1_clk_en, timer0_clk_en};
    integer err_count = 0, checks_done = 0, cycles = 0, req_cnt = 0, i;
    reg [7:0] exp_r [0:15];
    reg [31:0] rd_v;

    // Block under test and core model
    spg_top spg_top_i (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .sleep_instr, .dma_enabled, .sleep_req_r, .sleep_mode_r, .usb_clk_en,
        .cipher_clk_en, .rtc_bus_clk_en, .event_routing_clk_en, .dma_clk_en,
        .conv_clk_en, .comp_clk_en, .two_wire_clk_en, .serial0_clk_en,
        .spi_clk_en, .fine_timer_ext_clk_en, .timer1_clk_en, .timer0_clk_en);
    spg_cpu_model spg_cpu_model_i (.ref_clk, .rst, .sleep_cmd, .dma_on,
        .sleep_instr, .dma_enabled);

    // Clock, cycle ceiling and sleep request count
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (sleep_req_r === 1'b1)
            req_cnt <= req_cnt + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            end_of_test;
        end
    end

    // ==================================================================
    // Helpers: expected enables, compare, bus cycle, write and verify
    function [30:0] exp_en();
        integer b;
        exp_en = {~exp_r[0][6], ~exp_r[0][4], ~exp_r[0][2], ~exp_r[0][1],
            ~exp_r[0][0], ~exp_r[1][1:0], 24'h0};
        for (b = 0; b < 24; b = b + 1)
            exp_en[b] = ~exp_r[3 + b % 4][b < 20 ? b / 4 : 6];
    endfunction
    task check(input string nm, input [31:0] e, input [31:0] g);
        checks_done = checks_done + 1;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_count = err_count + 1;
        end
    endtask
    task bus(input wr, input [3:0] w, input [7:0] dt);
        integer n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= {w, 2'b00};
        avs_writedata <= {24'h0, dt};
        avs_byteenable <= be_v;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
            n = n + 1;
        end
        check("wait cycles", 32'd1, n);
        rd_v = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task wchk(input [3:0] w, input [7:0] dt);
        reg [7:0] v;
        reg [30:0] e;
        v = dt & (w <= 4'h8 ? MSK[w*8 +: 8] : 8'h00);
        if (w == 4'h0 && dma_enabled === 1'b1 && exp_r[0][0] === 1'b0)
            v[0] = 1'b0;
        exp_r[w] = v;
        bus(1'b1, w, dt);
        bus(1'b0, w, 8'h00);
        e = exp_en();
        check("register", {24'h0, v}, rd_v);
        check("gen", e[30:24], en_all[30:24]);
        check("port", e[23:0], en_all[23:0]);
    endtask

    // ==================================================================
    // Scenarios
    task t_reset(input pulse);
        if (pulse) begin
            @(posedge ref_clk);
            rst <= 1'b1;
            repeat (2) @(posedge ref_clk);
            rst <= 1'b0;
        end
        for (i = 0; i < 16; i = i + 1)
            exp_r[i] = 8'h00;
        for (i = 0; i < 10; i = i + 1) begin
            bus(1'b0, i[3:0], 8'h00);
            check("reset value", 32'h0, rd_v);
        end
        check("reset enables", {1'b0, {31{1'b1}}}, en_all);
        check("reset mode", 32'h0, sleep_mode_r);
    endtask
    task t_regs;
        integer w, k;
        for (w = 0; w < 9; w = w + 1)
            for (k = 0; k < 4; k = k + 1)
                wchk(w[3:0], k == 0 ? 8'hff : k == 1 ? 8'h55 :
                    k == 2 ? 8'haa : 8'h00);
    endtask
    task t_dma;
        dma_on <= 1'b1;
        repeat (2) @(posedge ref_clk);
        wchk(4'h0, 8'h01);
        dma_on <= 1'b0;
        repeat (2) @(posedge ref_clk);
        wchk(4'h0, 8'h01);
        dma_on <= 1'b1;
        repeat (2) @(posedge ref_clk);
        wchk(4'h0, 8'h00);
        dma_on <= 1'b0;
    endtask
    task t_sleep;
        integer c, a;
        reg ok;
        reg [2:0] em;
        em = 3'h0;
        for (c = 0; c < 8; c = c + 1)
            for (a = 0; a < 2; a = a + 1) begin
                wchk(4'h8, {4'h0, c[2:0], a[0]});
                req_cnt = 0;
                @(posedge ref_clk);
                sleep_cmd <= 1'b1;
                @(posedge ref_clk);
                sleep_cmd <= 1'b0;
                repeat (4) @(posedge ref_clk);
                ok = a && !(c == 1 || c == 4 || c == 5);
                if (ok)
                    em = c[2:0];
                check("sleep count", ok, req_cnt);
                check("sleep mode", em, sleep_mode_r);
                bus(1'b0, 4'h9, 8'h00);
                check("status", {28'h0, em, 1'b0}, rd_v);
                wchk(4'h8, 8'h00);
            end
    endtask

    // Verdict and end of run
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset(1'b0);
        t_regs;
        t_dma;
        // Converter and comparator count as disabled before gating
        wchk(4'h1, 8'h03);
        t_sleep;
        be_v = 4'h0;
        bus(1'b1, 4'h3, 8'h5f);
        be_v = 4'h1;
        bus(1'b0, 4'h3, 8'h00);
        check("lane 0 write", {24'h0, exp_r[3]}, rd_v);
        wchk(4'h3, 8'h5f);
        t_reset(1'b1);
        end_of_test;
    end
endmodule // testbench

// >>> verilog/spg_gate_bank.v
// One gate register with write mask and gated clock enables
`timescale 1ns/1ps
`include "spg_map.vh"

module spg_gate_bank (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Write port
    input wire wr_en,
    input wire [7:0] wr_data,
    input wire [7:0] wr_mask,
    input wire [7:0] set_block,
    // State
    output reg [7:0] gate_r,
    output wire [7:0] clk_en
);

    reg [7:0] gate_nxt;
    integer i;

    // Masked write; blocked bits may clear but not newly set
    always @* begin
        gate_nxt = gate_r;
        for (i = 0; i < 8; i = i + 1) begin
            if (wr_en && wr_mask[i]) begin
                if (!(wr_data[i] && !gate_r[i] && set_block[i])) begin
                    gate_nxt[i] = wr_data[i];
                end
            end
        end
    end

    // Register with reset to zero
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gate_r <= `SPG_RESET;
        end else begin
            gate_r <= gate_nxt;
        end
    end

    // A set bit stops the peripheral's clock enable, freezing its state
    assign clk_en = ~gate_r;

endmodule // spg_gate_bank

// >>> verilog/spg_mode_decode.v
// Sleep mode field decoder
`timescale 1ns/1ps
`include "spg_map.vh"

module spg_mode_decode (
    // Mode field
    input wire [2:0] sleep_mode_select,
    // Decoded one-hot: idle, deep off, counter keep, osc keep, osc+counter
    output reg [4:0] mode_onehot,
    output reg mode_valid
);

    // Decode legal codes; reserved codes give no mode
    always @* begin
        mode_onehot = 5'h00;
        mode_valid = 1'b1;
        case (sleep_mode_select)
            `SPG_MODE_IDLE: mode_onehot = 5'h01;
            `SPG_MODE_DEEP_OFF: mode_onehot = 5'h02;
            `SPG_MODE_COUNTER_KEEP: mode_onehot = 5'h04;
            `SPG_MODE_OSC_KEEP: mode_onehot = 5'h08;
            `SPG_MODE_OSC_COUNTER_KEEP: mode_onehot = 5'h10;
            default: mode_valid = 1'b0;
        endcase
    end

endmodule // spg_mode_decode

// >>> verilog/spg_top.v
// Sleep control and peripheral clock gating with Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "spg_map.vh"

module spg_top (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Avalon-MM slave
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // CPU core
    input wire sleep_instr,
    input wire dma_enabled,
    // Sleep request to clock system
    output reg sleep_req_r,
    output reg [2:0] sleep_mode_r,
    // Clock enables: general {usb,cipher,rtc_bus,event,dma}
    output wire usb_clk_en,
    output wire cipher_clk_en,
    output wire rtc_bus_clk_en,
    output wire event_routing_clk_en,
    output wire dma_clk_en,
    // Port A analog enables
    output wire conv_clk_en,
    output wire comp_clk_en,
    // Port C..F enables, one bit per port, bit 0 = C
    output wire [3:0] two_wire_clk_en,
    output wire [3:0] serial0_clk_en,
    output wire [3:0] spi_clk_en,
    output wire [3:0] fine_timer_ext_clk_en,
    output wire [3:0] timer1_clk_en,
    output wire [3:0] timer0_clk_en
);

    // ======================================================================
    // Bus handshake: one wait cycle, then answer
    // ======================================================================
    // Handshake state and strobes
    reg ack_r;
    reg ack_nxt;
    wire req;
    wire wr_go;
    wire rd_load;

    // Request, wait and accept strobes
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr_go = avs_write & ack_r & avs_byteenable[0]; // Lane 0 only
    assign rd_load = avs_read & ~ack_r; // Read word captured in wait cycle

    // Ack rises for one cycle after the single wait cycle
    always @* begin
        ack_nxt = 1'b0;
        if (req && !ack_r) begin
            ack_nxt = 1'b1;
        end
    end

    // Ack pulses on the second cycle of each request
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    // Index selects a word; byte address bits 1:0 are ignored
    wire [3:0] idx = avs_address[5:2];

    function is_idx;
        input [3:0] a;
        input [3:0] b;
        begin
            is_idx = (a == b);
        end
    endfunction

    // ======================================================================
    // Word selects of the register map
    // ======================================================================
    wire sel_gen;
    wire sel_pa;
    wire sel_ctrl;

    // One select each for the general, port A and control words
    assign sel_gen = is_idx(idx, `SPG_IDX_GEN);
    assign sel_pa = is_idx(idx, `SPG_IDX_PA);
    assign sel_ctrl = is_idx(idx, `SPG_IDX_CTRL);

    // ======================================================================
    // Sleep control register
    // ======================================================================
    // Control register and its next value
    reg [7:0] sleep_ctrl_r;
    reg [7:0] sleep_ctrl_nxt;

    // Only bits 3:0 are kept; upper bits read zero
    always @* begin
        sleep_ctrl_nxt = sleep_ctrl_r;
        if (wr_go && sel_ctrl) begin
            sleep_ctrl_nxt = avs_writedata[7:0] & `SPG_MASK_CTRL;
        end
    end

    // Control register, cleared by reset
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sleep_ctrl_r <= `SPG_RESET;
        end else begin
            sleep_ctrl_r <= sleep_ctrl_nxt;
        end
    end

    wire sleep_allow = sleep_ctrl_r[`SPG_SLEEP_ALLOW_BIT];
    wire [2:0] sleep_mode_select = sleep_ctrl_r[`SPG_MODE_MSB:`SPG_MODE_LSB];
    wire [4:0] mode_onehot;
    wire mode_valid;

    // Mode field decode; reserved codes clear the valid flag
    spg_mode_decode u_dec (
        .sleep_mode_select(sleep_mode_select),
        .mode_onehot(mode_onehot),
        .mode_valid(mode_valid)
    );

    // Mode code rebuilt from the one-hot decode; no valid bit gives idle
    function [2:0] onehot_code;
        input [4:0] oh;
        begin
            case (oh)
                5'h02: onehot_code = `SPG_MODE_DEEP_OFF;
                5'h04: onehot_code = `SPG_MODE_COUNTER_KEEP;
                5'h08: onehot_code = `SPG_MODE_OSC_KEEP;
                5'h10: onehot_code = `SPG_MODE_OSC_COUNTER_KEEP;
                default: onehot_code = `SPG_MODE_IDLE;
            endcase
        end
    endfunction

    reg sleep_req_nxt;
    reg [2:0] sleep_mode_nxt;
    wire sleep_take;

    // Sleep request only with allow set; reserved mode codes are refused
    assign sleep_take = sleep_instr & sleep_allow & mode_valid;

    // Request lasts one cycle; the mode holds until the next taken sleep
    always @* begin
        sleep_req_nxt = sleep_take;
        sleep_mode_nxt = sleep_mode_r;
        if (sleep_take) begin
            sleep_mode_nxt = onehot_code(mode_onehot);
        end
    end

    // Sleep request pulse and held mode code
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sleep_req_r <= 1'b0;
            sleep_mode_r <= `SPG_MODE_IDLE;
        end else begin
            sleep_req_r <= sleep_req_nxt;
            sleep_mode_r <= sleep_mode_nxt;
        end
    end

    // ======================================================================
    // Gate registers: general, A, C, D, E, F
    // ======================================================================
    wire [7:0] gen_r;
    wire [7:0] pa_r;
    wire [7:0] gen_en;
    wire [7:0] pa_en;
    wire [7:0] dma_block;
    wire gen_wr;
    wire pa_wr;

    // Only the DMA bit is refused, and only while the controller runs
    assign dma_block = {7'h00, dma_enabled} << `SPG_GEN_DMA;

    // Write strobes of the general and port A words
    assign gen_wr = wr_go & sel_gen;
    assign pa_wr = wr_go & sel_pa;

    // General word: a DMA gate cannot be newly set while it runs
    spg_gate_bank u_gen (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(gen_wr),
        .wr_data(avs_writedata[7:0]),
        .wr_mask(`SPG_MASK_GEN),
        .set_block(dma_block),
        .gate_r(gen_r),
        .clk_en(gen_en)
    );

    // Port A word: converter and comparator gates
    spg_gate_bank u_pa (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(pa_wr),
        .wr_data(avs_writedata[7:0]),
        .wr_mask(`SPG_MASK_PA),
        .set_block(8'h00),
        .gate_r(pa_r),
        .clk_en(pa_en)
    );

    // Per-port index and mask tables, C..F
    wire [15:0] port_idx = {`SPG_IDX_PF, `SPG_IDX_PE, `SPG_IDX_PD, `SPG_IDX_PC};
    wire [31:0] port_mask = {`SPG_MASK_PF, `SPG_MASK_PE, `SPG_MASK_PD,
        `SPG_MASK_PC};
    wire [31:0] port_r;
    wire [31:0] port_en;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_port
            wire port_wr;

            // Write strobe of this port word
            assign port_wr = wr_go & is_idx(idx, port_idx[4*g+3:4*g]);

            spg_gate_bank u_p (
                .ref_clk(ref_clk),
                .rst(rst),
                .wr_en(port_wr),
                .wr_data(avs_writedata[7:0]),
                .wr_mask(port_mask[8*g+7:8*g]),
                .set_block(8'h00),
                .gate_r(port_r[8*g+7:8*g]),
                .clk_en(port_en[8*g+7:8*g])
            );
            // Absent peripherals never set, so their enable stays high
            assign two_wire_clk_en[g] = port_en[8*g+`SPG_PT_WIRE];
            assign spi_clk_en[g] = port_en[8*g+`SPG_PT_SPI];
            assign fine_timer_ext_clk_en[g] = port_en[8*g+`SPG_PT_FINE];
            assign timer1_clk_en[g] = port_en[8*g+`SPG_PT_TMR1];

            // Serial port and timer 0 exist in every port word
            assign serial0_clk_en[g] = port_en[8*g+`SPG_PT_SER];
            assign timer0_clk_en[g] = port_en[8*g+`SPG_PT_TMR0];
        end
    endgenerate

    // General word enables
    assign usb_clk_en = gen_en[`SPG_GEN_USB];
    assign cipher_clk_en = gen_en[`SPG_GEN_CIPHER];
    assign rtc_bus_clk_en = gen_en[`SPG_GEN_RTC];
    assign event_routing_clk_en = gen_en[`SPG_GEN_EVT];
    assign dma_clk_en = gen_en[`SPG_GEN_DMA];

    // Port A analog enables; the analog cores stop as well
    assign conv_clk_en = pa_en[`SPG_PA_CONV];
    assign comp_clk_en = pa_en[`SPG_PA_COMP];

    // ======================================================================
    // Read mux; status word shows the pending request and mode
    // ======================================================================
    reg [7:0] rd_byte;
    wire [7:0] status_byte;

    // Status word: pending request in bit 0, held mode above it
    assign status_byte = {4'h0, sleep_mode_r, sleep_req_r};

    // Register byte selected by the word index
    always @* begin
        case (idx)
            `SPG_IDX_GEN: rd_byte = gen_r;
            `SPG_IDX_PA: rd_byte = pa_r;
            `SPG_IDX_PC: rd_byte = port_r[7:0];
            `SPG_IDX_PD: rd_byte = port_r[15:8];
            `SPG_IDX_PE: rd_byte = port_r[23:16];
            `SPG_IDX_PF: rd_byte = port_r[31:24];
            `SPG_IDX_CTRL: rd_byte = sleep_ctrl_r;
            `SPG_IDX_STAT: rd_byte = status_byte;
            default: rd_byte = 8'h00;
        endcase
    end

    reg [31:0] readdata_nxt;

    // Read word: register byte in lane 0, upper lanes zero
    always @* begin
        readdata_nxt = avs_readdata;
        if (rd_load) begin
            readdata_nxt = {24'h000000, rd_byte};
        end
    end

    // Read data registered in the wait cycle, standing at the answer
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_readdata <= readdata_nxt;
        end
    end

endmodule // spg_top
